// ### core/tpc_cfg.sv
// Power, shared pin and conversion configuration bank with interval timer
//
// Function
// - I/O use of pin skips auxiliary, battery
// - Both selected: battery measured, auxiliary dropped
// - Sequence end, interval zero: mode cleared
// - Power 00: everything powered down
// - Power 01 master: off, wake on touch
// - Power 01 slave/single: converter on demand
// - Power 10: converter, bias, oscillator always on
// - Bit 13 selects analog channel or I/O
// - Bit 10 sets pin active level
// - Bit 9 selects ratiometric or single-ended
// - Mode codes: none, single, slave, master
// - Interval timer restart per slave/master mode
`timescale 1ns/1ps
module tpc_cfg #(
	parameter int INTERVAL_BASE_CYC = tpc_pkg::INTERVAL_BASE_CYC,
	parameter int INTERVAL_STEP_CYC = tpc_pkg::INTERVAL_STEP_CYC
) (
	input  wire logic          clk_sys,
	input  wire logic          sys_rst,
	input  tpc_pkg::tpc_req_s  req,
	input  wire logic          touched,
	input  wire logic          conv_busy,
	input  wire logic          seq_done,
	input  wire logic          aux_requested,
	input  wire logic          batt_requested,
	input  wire logic          pad_in,
	output logic [15:0]        reg_rdata,
	output tpc_pkg::tpc_pwr_s  pwr_en,
	output logic               aux_measure_en,
	output logic               batt_measure_en,
	output logic               single_ended,
	output logic               conv_start,
	output logic [1:0]         conv_mode,
	output logic               pad_out,
	output logic               pad_oe
);

	tpc_pkg::tpc_state_s s_q;
	tpc_pkg::tpc_state_s s_d;
	tpc_pkg::tpc_pin_s   pin_q;

	logic [1:0]                 power;
	logic [1:0]                 mode;
	logic [7:0]                 interval;
	logic                       io_use;
	logic                       touch_rise;
	logic [tpc_pkg::CNT_W-1:0]  load_val;
	logic [15:0]                cfg2_view;

	assign power    = s_q.cfg2[tpc_pkg::POWER_HI:tpc_pkg::POWER_LO];
	assign mode     = s_q.cfg1[tpc_pkg::CONV_MODE_HI:tpc_pkg::CONV_MODE_LO];
	assign interval = s_q.cfg1[tpc_pkg::INTERVAL_HI:tpc_pkg::INTERVAL_LO];
	assign io_use   = s_q.cfg2[tpc_pkg::PIN_FUNC_BIT];
	assign touch_rise = touched & ~s_q.touch_prev;
	// Interval 1 is the base time, each further step adds one step time
	assign load_val = tpc_pkg::CNT_W'(INTERVAL_BASE_CYC
		+ (int'(interval) - 1) * INTERVAL_STEP_CYC);

	////////////////////////////////////////////////////////////////////////
	// Shared pin

	tpc_pin u_pin (
		.clk_sys          (clk_sys),
		.sys_rst          (sys_rst),
		.pin_func         (io_use),
		.pin_dir          (s_q.cfg2[tpc_pkg::PIN_DIR_BIT]),
		.pin_polarity_bit (s_q.cfg2[tpc_pkg::PIN_POL_BIT]),
		.pin_level_bit    (s_q.cfg2[tpc_pkg::PIN_LEVEL_BIT]),
		.pad_in           (pad_in),
		.pin_q            (pin_q)
	);

	// Input direction reads back the pin, not the stored bit
	always_comb begin
		cfg2_view = s_q.cfg2;
		if (io_use && s_q.cfg2[tpc_pkg::PIN_DIR_BIT]) begin
			cfg2_view[tpc_pkg::PIN_LEVEL_BIT] = pin_q.level_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_d = s_q;
		s_d.conv_start = 1'b0;
		s_d.touch_prev = touched;

		// Hardware clear first so a same-cycle host write takes priority
		if (seq_done && interval == tpc_pkg::INTERVAL_OFF) begin
			s_d.cfg1[tpc_pkg::CONV_MODE_HI:tpc_pkg::CONV_MODE_LO] =
				tpc_pkg::TPC_CONV_NONE;
		end
		if (req.wr_en) begin
			if (req.addr == tpc_pkg::ADDR_CFG1) begin
				s_d.cfg1 = req.wdata;
			end else if (req.addr == tpc_pkg::ADDR_CFG2) begin
				s_d.cfg2 = req.wdata;
			end
		end

		if (req.addr == tpc_pkg::ADDR_CFG1) begin
			s_d.rdata = s_q.cfg1;
		end else if (req.addr == tpc_pkg::ADDR_CFG2) begin
			s_d.rdata = cfg2_view;
		end else begin
			s_d.rdata = tpc_pkg::RDATA_UNMAPPED;
		end

		// Channel selection
		s_d.aux_en  = aux_requested & ~io_use & ~batt_requested;
		s_d.batt_en = batt_requested & ~io_use;
		s_d.single_ended = s_q.cfg2[tpc_pkg::REF_MODE_BIT];

		// Power policy
		case (power)
			tpc_pkg::TPC_PWR_OFF: begin
				s_d.pwr = '0;
			end
			tpc_pkg::TPC_PWR_ON: begin
				s_d.pwr.adc  = 1'b1;
				s_d.pwr.osc  = 1'b1;
				s_d.pwr.bias = 1'b1;
				s_d.pwr.temp = conv_busy;
			end
			default: begin
				// Code 11 shares the code 01 policy
				if (mode == tpc_pkg::TPC_CONV_MASTER) begin
					s_d.pwr.adc  = touched | conv_busy;
					s_d.pwr.osc  = touched | conv_busy;
					s_d.pwr.bias = touched | conv_busy;
					s_d.pwr.temp = touched | conv_busy;
				end else begin
					s_d.pwr.adc  = conv_busy;
					s_d.pwr.temp = conv_busy;
					s_d.pwr.osc  = 1'b1;
					s_d.pwr.bias = 1'b1;
				end
			end
		endcase

		// Interval timer
		case (s_q.tmr)
			tpc_pkg::TPC_TMR_IDLE: begin
				if (mode == tpc_pkg::TPC_CONV_MASTER && touch_rise && !conv_busy) begin
					s_d.conv_start = 1'b1;
				end else if (seq_done && interval != tpc_pkg::INTERVAL_OFF
					&& (mode == tpc_pkg::TPC_CONV_SLAVE
					|| (mode == tpc_pkg::TPC_CONV_MASTER && touched))) begin
					s_d.tmr = tpc_pkg::TPC_TMR_RUN;
					s_d.cnt = load_val;
				end
			end
			tpc_pkg::TPC_TMR_RUN: begin
				if (mode != tpc_pkg::TPC_CONV_SLAVE && mode != tpc_pkg::TPC_CONV_MASTER) begin
					s_d.tmr = tpc_pkg::TPC_TMR_IDLE;
				end else if (mode == tpc_pkg::TPC_CONV_MASTER && !touched) begin
					s_d.tmr = tpc_pkg::TPC_TMR_IDLE;
				end else if (s_q.cnt <= tpc_pkg::CNT_W'(1)) begin
					s_d.tmr = tpc_pkg::TPC_TMR_IDLE;
					s_d.conv_start = 1'b1;
				end else begin
					s_d.cnt = s_q.cnt - tpc_pkg::CNT_W'(1);
				end
			end
			default: begin
				s_d.tmr = tpc_pkg::TPC_TMR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_q <= '{cfg1: tpc_pkg::CFG1_RESET, cfg2: tpc_pkg::CFG2_RESET,
				tmr: tpc_pkg::TPC_TMR_IDLE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata       = s_q.rdata;
	assign pwr_en          = s_q.pwr;
	assign aux_measure_en  = s_q.aux_en;
	assign batt_measure_en = s_q.batt_en;
	assign single_ended    = s_q.single_ended;
	assign conv_start      = s_q.conv_start;
	assign conv_mode       = mode;
	assign pad_out         = pin_q.pad_out;
	assign pad_oe          = pin_q.pad_oe;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence seq_end_zero;
		seq_done && interval == tpc_pkg::INTERVAL_OFF && !req.wr_en;
	endsequence

	chk_io_skips_analog: assert property (
		$past(io_use) |-> !aux_measure_en && !batt_measure_en
	) else $error("analog channel enabled during I/O use");

	chk_batt_over_aux: assert property (
		$past(aux_requested && batt_requested && !io_use) |-> batt_measure_en && !aux_measure_en
	) else $error("auxiliary not dropped for battery");

	chk_mode_autoclear: assert property (
		seq_end_zero |=> conv_mode == tpc_pkg::TPC_CONV_NONE
	) else $error("conversion mode not cleared");

	chk_power_off: assert property (
		power == tpc_pkg::TPC_PWR_OFF |=> pwr_en == '0
	) else $error("blocks powered in shutdown");

	chk_master_wake: assert property (
		power[0] && mode == tpc_pkg::TPC_CONV_MASTER && !touched && !conv_busy
		|=> pwr_en == '0
	) else $error("master idle not powered down");

	chk_slave_osc_bias: assert property (
		power[0] && mode != tpc_pkg::TPC_CONV_MASTER
		|=> pwr_en.osc && pwr_en.bias && pwr_en.adc == $past(conv_busy)
	) else $error("slave power policy broken");

	chk_power_on: assert property (
		power == tpc_pkg::TPC_PWR_ON |=> pwr_en.adc && pwr_en.osc && pwr_en.bias
	) else $error("continuous power not held");

	chk_ref_mode: assert property (
		single_ended == $past(s_q.cfg2[tpc_pkg::REF_MODE_BIT])
	) else $error("reference mode not applied");

	chk_master_touch: assert property (
		mode == tpc_pkg::TPC_CONV_MASTER && touch_rise && !conv_busy
		&& s_q.tmr == tpc_pkg::TPC_TMR_IDLE |=> conv_start
	) else $error("touch did not start conversion");

	chk_master_release: assert property (
		mode == tpc_pkg::TPC_CONV_MASTER && !touched && s_q.tmr == tpc_pkg::TPC_TMR_RUN
		|=> s_q.tmr == tpc_pkg::TPC_TMR_IDLE && !conv_start
	) else $error("timer kept running after release");

endmodule

// ### core/tpc_pkg.sv
// Shared constants and types for the touch converter configuration bank
package tpc_pkg;

	localparam logic [7:0]  ADDR_CFG1       = 8'h01;
	localparam logic [7:0]  ADDR_CFG2       = 8'h02;
	localparam logic [15:0] CFG1_RESET      = 16'h0000;
	localparam logic [15:0] CFG2_RESET      = 16'h4040;
	localparam logic [15:0] RDATA_UNMAPPED  = 16'h0000;

	// Field positions of the power, pin and conversion configuration word
	localparam int POWER_HI        = 15;
	localparam int POWER_LO        = 14;
	localparam int PIN_FUNC_BIT    = 13;
	localparam int PIN_LEVEL_BIT   = 12;
	localparam int PIN_DIR_BIT     = 11;
	localparam int PIN_POL_BIT     = 10;
	localparam int REF_MODE_BIT    = 9;

	// Field positions of the conversion control word
	localparam int CONV_MODE_HI    = 11;
	localparam int CONV_MODE_LO    = 10;
	localparam int INTERVAL_HI     = 7;
	localparam int INTERVAL_LO     = 0;
	localparam logic [7:0] INTERVAL_OFF = 8'h00;

	// Interval timer: first step and step size, in ns, at a 8 ns clock
	localparam int CLK_PERIOD_NS      = 8;
	localparam int INTERVAL_BASE_NS   = 550000;
	localparam int INTERVAL_STEP_NS   = 35000;
	localparam int INTERVAL_BASE_CYC  = INTERVAL_BASE_NS / CLK_PERIOD_NS;
	localparam int INTERVAL_STEP_CYC  = INTERVAL_STEP_NS / CLK_PERIOD_NS;
	localparam int CNT_W              = 24;

	typedef enum logic [1:0] {
		TPC_PWR_OFF    = 2'b00,
		TPC_PWR_AUTO   = 2'b01,
		TPC_PWR_ON     = 2'b10,
		TPC_PWR_AUTO_B = 2'b11
	} tpc_power_e;

	typedef enum logic [1:0] {
		TPC_CONV_NONE   = 2'b00,
		TPC_CONV_SINGLE = 2'b01,
		TPC_CONV_SLAVE  = 2'b10,
		TPC_CONV_MASTER = 2'b11
	} tpc_conv_e;

	typedef enum logic [1:0] {
		TPC_TMR_IDLE = 2'b00,
		TPC_TMR_RUN  = 2'b01
	} tpc_tmr_e;

	typedef struct packed {
		logic adc;
		logic osc;
		logic bias;
		logic temp;
	} tpc_pwr_s;

	typedef struct packed {
		logic       wr_en;
		logic [7:0] addr;
		logic [15:0] wdata;
	} tpc_req_s;

	typedef struct packed {
		logic [15:0]        cfg1;
		logic [15:0]        cfg2;
		logic [15:0]        rdata;
		tpc_pwr_s           pwr;
		logic               aux_en;
		logic               batt_en;
		logic               single_ended;
		logic               conv_start;
		tpc_tmr_e           tmr;
		logic [CNT_W-1:0]   cnt;
		logic               touch_prev;
	} tpc_state_s;

	typedef struct packed {
		logic pad_out;
		logic pad_oe;
		logic level_in;
	} tpc_pin_s;

endpackage

// ### core/tpc_pin.sv
// Shared pin driver: general-purpose I/O with direction and polarity
`timescale 1ns/1ps
module tpc_pin (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic pin_func,
	input  wire logic pin_dir,
	input  wire logic pin_polarity_bit,
	input  wire logic pin_level_bit,
	input  wire logic pad_in,
	output tpc_pkg::tpc_pin_s pin_q
);

	tpc_pkg::tpc_pin_s pin_d;

	always_comb begin
		pin_d = pin_q;
		// Drive only in I/O use with output direction
		pin_d.pad_oe = pin_func & ~pin_dir;
		// Polarity bit set: logic one is the active level of the pin; clear: the level is inverted
		pin_d.pad_out = pin_polarity_bit ? pin_level_bit : ~pin_level_bit;
		pin_d.level_in = pin_polarity_bit ? pad_in : ~pad_in;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pin_q <= '0;
		end else begin
			pin_q <= pin_d;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	chk_pin_drive_enable: assert property (
		pin_q.pad_oe == $past(pin_func & ~pin_dir)
	) else $error("pin enable does not follow function and direction");

	chk_pin_polarity: assert property (
		$past(pin_func & ~pin_dir & ~pin_polarity_bit) |-> pin_q.pad_out == ~$past(pin_level_bit)
	) else $error("active low pin not inverted");

endmodule

// ### tb/tpc_host.sv
// Host model: writes and addresses the configuration words
`timescale 1ns/1ps
module tpc_host (
	input  wire logic         clk_sys,
	output tpc_pkg::tpc_req_s req
);
	initial req = '0;
	// One-cycle write strobe; afterwards the address stays on the word just written
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		req <= '{wr_en: 1'b1, addr: a, wdata: d};
		@(posedge clk_sys);
		// Released data is scrambled so nothing can rely on it lingering
		req <= '{wr_en: 1'b0, addr: a, wdata: ~d};
	endtask
	task automatic sel(input logic [7:0] a);
		req.addr <= a;
	endtask
endmodule

// ### tb/tpc_cfg_test.sv
// Self-checking bench for the power, pin and conversion configuration bank
`timescale 1ns/1ps
module tpc_cfg_test;
	localparam int BASE = 20;
	localparam int STEP = 5;
	typedef struct {int due; bit rd; logic [15:0] exp; logic [15:0] mask;} tpc_note_s;
	logic              clk_sys = 0, sys_rst = 1, touched = 0, conv_busy = 0, seq_done = 0;
	logic              aux_requested = 0, batt_requested = 0, pad_in = 0;
	tpc_pkg::tpc_req_s req;
	tpc_pkg::tpc_pwr_s pwr_en;
	logic [15:0]       reg_rdata;
	logic              aux_measure_en, batt_measure_en, single_ended, conv_start, pad_out, pad_oe;
	logic [1:0]        conv_mode;
	int                cyc = 0, err_total = 0, samples_checked = 0;
	tpc_note_s         q[$];
	wire logic [15:0]  outw = {pwr_en, aux_measure_en, batt_measure_en, single_ended,
		conv_start, conv_mode, pad_out, pad_oe, 4'h0};

	tpc_host tpc_host_i (.clk_sys(clk_sys), .req(req));
	tpc_cfg #(.INTERVAL_BASE_CYC(BASE), .INTERVAL_STEP_CYC(STEP)) tpc_cfg_i (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .touched(touched),
		.conv_busy(conv_busy), .seq_done(seq_done), .aux_requested(aux_requested),
		.batt_requested(batt_requested), .pad_in(pad_in), .reg_rdata(reg_rdata),
		.pwr_en(pwr_en), .aux_measure_en(aux_measure_en), .batt_measure_en(batt_measure_en),
		.single_ended(single_ended), .conv_start(conv_start), .conv_mode(conv_mode),
		.pad_out(pad_out), .pad_oe(pad_oe));

	initial forever #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;

	////////////////////////////////////////////////////////////////
	task automatic tk(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// Due is counted from the edge before the one the caller has just passed
	task automatic note(input int d, input bit rd, input logic [15:0] e, input logic [15:0] m);
		q.push_back('{cyc + d, rd, e, m});
	endtask
	task automatic pulse;
		seq_done <= 1'b1;
		@(posedge clk_sys);
		seq_done <= 1'b0;
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	always @(negedge clk_sys) begin : mon
		tpc_note_s   n;
		logic [15:0] seen;
		while (q.size() > 0 && q[0].due <= cyc) begin
			n = q.pop_front();
			seen = (n.rd ? reg_rdata : outw) & n.mask;
			samples_checked++;
			if (seen !== (n.exp & n.mask)) begin
				err_total++;
				$display("[FAIL] %s exp %h seen %h", n.rd ? "reg_rdata" : "outputs",
					n.exp & n.mask, seen);
			end
		end
	end

	initial begin
		#200000;
		err_total++;
		summarize();
	end

	////////////////////////////////////////////////////////////////
	initial begin
		logic [1:0]  pm;
		logic [15:0] w, r;
		logic        cb, tc, ar, br, pi;
		void'($urandom(32'h572e));
		tk(2);
		sys_rst <= 1'b0;
		tpc_host_i.sel(8'h02);
		note(3, 1, 16'h4040, 16'hffff);
		tk(4);
		tpc_host_i.sel(8'h05);
		note(3, 1, 16'h0000, 16'hffff);
		tk(4);
		// Every power code under slave and master sequencing
		for (int i = 0; i < 8; i++) begin
			pm = 2'(i);
			cb = 1'($urandom);
			tc = 1'($urandom);
			conv_busy <= cb;
			touched <= tc;
			tpc_host_i.wr(8'h01, i < 4 ? 16'h0800 : 16'h0c00);
			tpc_host_i.wr(8'h02, {pm, 14'h0040});
			note(4, 0, {pm == 0 ? 4'h0 : pm == 2 ? {3'b111, cb} : i >= 4 ? {4{cb | tc}}
				: {cb, 2'b11, cb}, 12'h0}, 16'hf000);
			tk(5);
		end
		// Shared pin, channel priority and reference mode
		for (int i = 0; i < 16; i++) begin
			w = 16'($urandom);
			{ar, br, pi} = 3'($urandom);
			aux_requested <= ar;
			batt_requested <= br;
			pad_in <= pi;
			tpc_host_i.wr(8'h02, w);
			r = w;
			if (w[13] && w[11]) r[12] = w[10] ? pi : ~pi;
			note(4, 0, {4'h0, ~w[13] & ar & ~br, ~w[13] & br, w[9], 3'h0, w[10] ? w[12] : ~w[12],
				w[13] & ~w[11], 4'h0}, 16'h0e30);
			note(4, 1, r, 16'hffff);
			tk(5);
		end
		conv_busy <= 1'b0;
		touched <= 1'b0;
		tpc_host_i.wr(8'h02, 16'h8040);
		// Each mode code, and the automatic clear with interval zero
		for (int m = 0; m < 4; m++) begin
			tpc_host_i.wr(8'h01, 16'(m) << 10);
			note(4, 0, 16'(m) << 6, 16'h00c0);
			tk(5);
			if (m == 1 || m == 2) begin
				pulse();
				note(3, 0, 16'h0000, 16'h00c0);
				tk(4);
			end
		end
		// Slave interval timer, shortest and a longer count
		for (int n = 1; n <= 3; n += 2) begin
			tpc_host_i.wr(8'h01, 16'h0800 | 16'(n));
			tk(3);
			pulse();
			note(1 + BASE + (n - 1) * STEP, 0, 16'h0180, 16'h01c0);
			note(2 + BASE + (n - 1) * STEP, 0, 16'h0080, 16'h01c0);
			tk(6 + BASE + (n - 1) * STEP);
		end
		// Master sequencing: a touch starts at once, a release stops the timer
		tpc_host_i.wr(8'h01, 16'h0c01);
		touched <= 1'b1;
		note(2, 0, 16'h01c0, 16'h01c0);
		note(3, 0, 16'h00c0, 16'h01c0);
		tk(3);
		pulse();
		tk(5);
		touched <= 1'b0;
		// Would be the expiry edge had the release not stopped the timer
		note(16, 0, 16'h00c0, 16'h01c0);
		tk(20);
		touched <= 1'b1;
		note(2, 0, 16'h01c0, 16'h01c0);
		tk(6);
		summarize();
	end
endmodule
